// >>> hdl/dopag_consts.vh
/*
 Constants for the data operand address generator: register offsets on the
 AHB-Lite bus, field positions, reset values and mode codes.
 Assumes inclusion by bare name from the design files.
*/
`ifndef DOPAG_CONSTS_VH
`define DOPAG_CONSTS_VH

// Register byte offsets
`define DOPAG_OFF_CTRL 12'h000
`define DOPAG_OFF_BANK 12'h004
`define DOPAG_OFF_PTR0 12'h008
`define DOPAG_OFF_PTR1 12'h00C
`define DOPAG_OFF_PTR2 12'h010
`define DOPAG_OFF_STAT 12'h014
`define DOPAG_OFF_CNT 12'h018

// Control fields
`define DOPAG_CTRL_XIS 0

// Reset values
`define DOPAG_RST_BANK 4'h0
`define DOPAG_RST_PTR 12'h000

// Addressing mode codes reported in status
`define DOPAG_MODE_INH 3'h0
`define DOPAG_MODE_LIT 3'h1
`define DOPAG_MODE_DIR 3'h2
`define DOPAG_MODE_IND 3'h3
`define DOPAG_MODE_MOV 3'h4
`define DOPAG_MODE_IDX 3'h5

// Special register locations in the data map
`define DOPAG_SFR_BANK 12'hFE0
`define DOPAG_SFR_PTR0L 12'hFE9
`define DOPAG_SFR_PTR0H 12'hFEA
`define DOPAG_SFR_PTR1L 12'hFE1
`define DOPAG_SFR_PTR1H 12'hFE2
`define DOPAG_SFR_PTR2L 12'hFD9
`define DOPAG_SFR_PTR2H 12'hFDA
// Alias low bytes: pointer n alias base at 8'hEF, 8'hE7, 8'hDF
`define DOPAG_ALIAS0 8'hEF
`define DOPAG_ALIAS1 8'hE7
`define DOPAG_ALIAS2 8'hDF
// Access bank split: below goes to bank 0, at or above to bank F
`define DOPAG_ACC_SPLIT 8'h80

`endif

// >>> hdl/dopag_ptr_file.v
/*
 Pointer file: three 12-bit indirect pointers held in a small register memory.
 Read data are registered. Assumes one write per cycle from the main block.
*/
`timescale 1ns/1ps
`include "dopag_consts.vh"

module dopag_ptr_file #(
    parameter AW = 12
) (
    input wire clk,
    input wire rst,
    input wire we,
    input wire [1:0] waddr,
    input wire [AW-1:0] wdata,
    output reg [AW-1:0] rd0,
    output reg [AW-1:0] rd1,
    output reg [AW-1:0] rd2
);
    reg [AW-1:0] mem [0:2]; // Pointer storage
    integer i;

    ////////////////////////////////////////////////////////////////////////
    // Storage with synchronous clear
    always @(posedge clk) begin
        if (rst) begin
            for (i = 0; i < 3; i = i + 1) begin
                mem[i] <= `DOPAG_RST_PTR;
            end
        end else if (we && waddr != 2'h3) begin
            mem[waddr] <= wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered read data; lags a write by one cycle
    always @(posedge clk) begin
        if (rst) begin
            rd0 <= `DOPAG_RST_PTR;
            rd1 <= `DOPAG_RST_PTR;
            rd2 <= `DOPAG_RST_PTR;
        end else begin
            rd0 <= mem[0];
            rd1 <= mem[1];
            rd2 <= mem[2];
        end
    end
endmodule // dopag_ptr_file

// >>> hdl/dopag_top.v
/*
 Data operand address generator of an 8-bit core. Takes a decoded instruction
 (opcode word plus a one-cycle strobe) and produces the data memory address,
 destination choice and pointer updates. Registers sit on AHB-Lite.
 Assumes: the decoder holds the opcode stable while dec_valid is high for one
 cycle; the decoder spaces strobes by at least three cycles (pointer read lag).
*/
`timescale 1ns/1ps
`include "dopag_consts.vh"

module dopag_top #(
    parameter AW = 12
) (
    input wire clk,
    input wire rst,
    // Decoder side
    input wire dec_valid,
    input wire [15:0] dec_opcode,
    input wire [15:0] dec_opcode2,
    input wire [7:0] dec_wreg,
    // Data memory writes of special registers seen by this block
    input wire mem_we,
    input wire [AW-1:0] mem_waddr,
    input wire [7:0] mem_wdata,
    // Results
    output reg op_valid,
    output reg [2:0] op_mode,
    output reg [AW-1:0] op_src_addr,
    output reg [AW-1:0] op_dst_addr,
    output reg op_dst_wreg,
    output reg op_src_mem,
    output reg [19:0] op_literal,
    // AHB-Lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg hresp,
    output reg [31:0] hrdata
);
    reg extended_isa_enable; // Software copy of configuration setting
    reg [3:0] bank_pointer_reg; // Upper address nibble for banked access
    reg [15:0] dec_count; // Decoded instruction count, read by software
    reg ph_wr; // Pending write data phase
    reg [11:0] ph_addr; // Latched address of data phase
    reg pf_we; // Pointer file write
    reg [1:0] pf_waddr;
    reg [AW-1:0] pf_wdata;
    wire [AW-1:0] ptr0;
    wire [AW-1:0] ptr1;
    wire [AW-1:0] ptr2;

    ////////////////////////////////////////////////////////////////////////
    // Pointer storage
    // Read data come out of a register, so a write shows two edges later;
    // the decoder must space strobes that depend on a fresh pointer.
    dopag_ptr_file #(.AW(AW)) dopag_ptr_file_i (
        .clk(clk),
        .rst(rst),
        .we(pf_we),
        .waddr(pf_waddr),
        .wdata(pf_wdata),
        .rd0(ptr0),
        .rd1(ptr1),
        .rd2(ptr2)
    );

    ////////////////////////////////////////////////////////////////////////
    // Decode helpers
    // Which pointer an alias low byte names; 3 means none. Aliases sit in the
    // Access Bank upper half, five bytes each: plain, inc, dec, pre-inc, +W
    function [1:0] alias_ptr;
        input [7:0] a;
        begin
            if (a <= `DOPAG_ALIAS0 && a > `DOPAG_ALIAS0 - 8'h05) begin
                alias_ptr = 2'h0;
            end else if (a <= `DOPAG_ALIAS1 && a > `DOPAG_ALIAS1 - 8'h05) begin
                alias_ptr = 2'h1;
            end else if (a <= `DOPAG_ALIAS2 && a > `DOPAG_ALIAS2 - 8'h05) begin
                alias_ptr = 2'h2;
            end else begin
                alias_ptr = 2'h3;
            end
        end
    endfunction

    // Form a full address from the 8-bit field and access bit
    // With the access bit clear the field splits between bank 0 and bank F
    function [11:0] direct_addr;
        input [7:0] f;
        input acc;
        input [3:0] bank;
        begin
            if (acc) begin
                direct_addr = {bank, f};
            end else if (f < `DOPAG_ACC_SPLIT) begin
                direct_addr = {4'h0, f};
            end else begin
                direct_addr = {4'hF, f};
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Opcode classification (combinational)
    reg [2:0] next_mode;
    reg [11:0] next_src;
    reg [11:0] next_dst;
    reg next_wreg;
    reg next_mem;
    reg [19:0] next_lit;
    reg [7:0] f8;
    reg acc;
    reg is_byte;
    reg [1:0] ap;
    reg [11:0] pval;
    reg [2:0] akind;
    reg [7:0] adiff; // Distance below the alias base, full byte
    always @* begin
        f8 = dec_opcode[7:0];
        acc = dec_opcode[8];
        next_mode = `DOPAG_MODE_INH;
        next_src = 12'h000;
        next_dst = 12'h000;
        next_wreg = 1'b0;
        next_mem = 1'b0;
        next_lit = 20'h00000;
        is_byte = 1'b0;
        ap = 2'h3;
        pval = 12'h000;
        akind = 3'h0;
        adiff = 8'h00;
        // Program memory is never addressed here; only data operands
        if (dec_opcode[15:8] == 8'h00) begin
            next_mode = `DOPAG_MODE_INH;
        end else if (dec_opcode[15:12] == 4'hC) begin
            next_mode = `DOPAG_MODE_MOV;
            next_src = dec_opcode[11:0];
            next_dst = dec_opcode2[11:0];
            next_mem = 1'b1;
        end else if (dec_opcode[15:12] == 4'hE || dec_opcode[15:8] == 8'h0F
                     || dec_opcode[15:8] == 8'h0E) begin
            next_mode = `DOPAG_MODE_LIT;
            if (dec_opcode[15:12] == 4'hE) begin
                next_lit = {dec_opcode2[11:0], dec_opcode[7:0]};
            end else begin
                next_lit = {12'h000, dec_opcode[7:0]};
                next_wreg = 1'b1;
            end
        end else if (dec_opcode[15:12] >= 4'h1 && dec_opcode[15:12] <= 4'hB) begin
            is_byte = 1'b1;
        end
        if (is_byte) begin
            next_mem = 1'b1;
            if (extended_isa_enable && !acc && f8 <= 8'h5F) begin
                // Indexed literal offset only with extension on
                next_mode = `DOPAG_MODE_IDX;
                next_src = ptr2 + {4'h0, f8};
            end else begin
                // Core behaviour otherwise
                next_mode = `DOPAG_MODE_DIR;
                next_src = direct_addr(f8, acc, bank_pointer_reg);
                if (!acc && f8 >= `DOPAG_ACC_SPLIT) begin
                    ap = alias_ptr(f8);
                end
            end
            if (ap != 2'h3) begin
                next_mode = `DOPAG_MODE_IND;
                case (ap)
                    2'h0: pval = ptr0;
                    2'h1: pval = ptr1;
                    default: pval = ptr2;
                endcase
                // Byte distance below the alias base picks the access kind;
                // only the low three bits matter once the alias matched
                adiff = (ap == 2'h0) ? (`DOPAG_ALIAS0 - f8) :
                        (ap == 2'h1) ? (`DOPAG_ALIAS1 - f8) : (`DOPAG_ALIAS2 - f8);
                akind = adiff[2:0];
                if (akind == 3'h3) begin
                    next_src = pval + 12'h001; // Pre-increment
                end else if (akind == 3'h4) begin
                    next_src = pval + {{4{dec_wreg[7]}}, dec_wreg};
                end else begin
                    next_src = pval;
                end
            end
            // Bits 15:12 at 7 or above: bit-oriented ops write the operated register
            if (dec_opcode[15:12] >= 4'h7) begin
                next_wreg = 1'b0;
            end else if (dec_opcode[9]) begin
                next_wreg = 1'b0;
            end else begin
                next_wreg = 1'b1;
            end
            next_dst = next_src;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Result registers
    // Fields hold between strobes so the core may sample them late
    always @(posedge clk) begin
        if (rst) begin
            op_valid <= 1'b0;
            op_mode <= `DOPAG_MODE_INH;
            op_src_addr <= 12'h000;
            op_dst_addr <= 12'h000;
            op_dst_wreg <= 1'b0;
            op_src_mem <= 1'b0;
            op_literal <= 20'h00000;
            dec_count <= 16'h0000;
        end else begin
            op_valid <= dec_valid;
            if (dec_valid) begin
                op_mode <= next_mode;
                op_src_addr <= next_src;
                op_dst_addr <= next_dst;
                op_dst_wreg <= next_wreg;
                op_src_mem <= next_mem;
                op_literal <= next_lit;
                dec_count <= dec_count + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pointer update source: alias increments and decrements first, then memory-mapped writes,
    // then bus writes. Only one path is taken per cycle; the others are lost,
    // so software should not race the core on the same pointer.
    wire bus_wr = ph_wr;
    always @(posedge clk) begin
        if (rst) begin
            pf_we <= 1'b0;
            pf_waddr <= 2'h3;
            pf_wdata <= 12'h000;
            bank_pointer_reg <= `DOPAG_RST_BANK;
        end else begin
            pf_we <= 1'b0;
            if (dec_valid && ap != 2'h3 && akind != 3'h0 && akind != 3'h4) begin
                pf_we <= 1'b1;
                pf_waddr <= ap;
                if (akind == 3'h2) begin
                    pf_wdata <= pval - 12'h001; // Post-decrement
                end else begin
                    pf_wdata <= pval + 12'h001; // Post and pre increment
                end
            end else if (mem_we) begin
                // Pointers and bank register live in the data map
                // Byte writes merge with the other half of the current value;
                // that value lags, so byte writes to one pointer must be spaced
                if (mem_waddr == `DOPAG_SFR_BANK) begin
                    bank_pointer_reg <= mem_wdata[3:0];
                end else if (mem_waddr == `DOPAG_SFR_PTR0L) begin
                    pf_we <= 1'b1; pf_waddr <= 2'h0; pf_wdata <= {ptr0[11:8], mem_wdata};
                end else if (mem_waddr == `DOPAG_SFR_PTR0H) begin
                    pf_we <= 1'b1; pf_waddr <= 2'h0; pf_wdata <= {mem_wdata[3:0], ptr0[7:0]};
                end else if (mem_waddr == `DOPAG_SFR_PTR1L) begin
                    pf_we <= 1'b1; pf_waddr <= 2'h1; pf_wdata <= {ptr1[11:8], mem_wdata};
                end else if (mem_waddr == `DOPAG_SFR_PTR1H) begin
                    pf_we <= 1'b1; pf_waddr <= 2'h1; pf_wdata <= {mem_wdata[3:0], ptr1[7:0]};
                end else if (mem_waddr == `DOPAG_SFR_PTR2L) begin
                    pf_we <= 1'b1; pf_waddr <= 2'h2; pf_wdata <= {ptr2[11:8], mem_wdata};
                end else if (mem_waddr == `DOPAG_SFR_PTR2H) begin
                    pf_we <= 1'b1; pf_waddr <= 2'h2; pf_wdata <= {mem_wdata[3:0], ptr2[7:0]};
                end
            end else if (bus_wr) begin
                // Bus view of the same registers
                if (ph_addr == `DOPAG_OFF_BANK) begin
                    bank_pointer_reg <= hwdata[3:0];
                end else if (ph_addr == `DOPAG_OFF_PTR0) begin
                    pf_we <= 1'b1; pf_waddr <= 2'h0; pf_wdata <= hwdata[11:0];
                end else if (ph_addr == `DOPAG_OFF_PTR1) begin
                    pf_we <= 1'b1; pf_waddr <= 2'h1; pf_wdata <= hwdata[11:0];
                end else if (ph_addr == `DOPAG_OFF_PTR2) begin
                    pf_we <= 1'b1; pf_waddr <= 2'h2; pf_wdata <= hwdata[11:0];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: zero wait states, OKAY always, writes in data phase
    // hresp and hreadyout are fixed after reset: no waits, no errors
    wire ahb_go = hsel && hready && htrans[1];
    always @(posedge clk) begin
        if (rst) begin
            ph_wr <= 1'b0;
            ph_addr <= 12'h000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
            extended_isa_enable <= 1'b0;
        end else begin
            ph_wr <= ahb_go && hwrite;
            if (ahb_go) begin
                ph_addr <= haddr[11:0];
            end
            if (ph_wr && ph_addr == `DOPAG_OFF_CTRL) begin
                extended_isa_enable <= hwdata[`DOPAG_CTRL_XIS];
            end
            // Read data registered in the address phase, valid in data phase
            if (ahb_go && !hwrite) begin
                if (haddr[11:0] == `DOPAG_OFF_CTRL) begin
                    hrdata <= {31'h0, extended_isa_enable};
                end else if (haddr[11:0] == `DOPAG_OFF_BANK) begin
                    hrdata <= {28'h0, bank_pointer_reg};
                end else if (haddr[11:0] == `DOPAG_OFF_PTR0) begin
                    hrdata <= {20'h0, ptr0};
                end else if (haddr[11:0] == `DOPAG_OFF_PTR1) begin
                    hrdata <= {20'h0, ptr1};
                end else if (haddr[11:0] == `DOPAG_OFF_PTR2) begin
                    hrdata <= {20'h0, ptr2};
                end else if (haddr[11:0] == `DOPAG_OFF_STAT) begin
                    hrdata <= {28'h0, op_dst_wreg, op_mode};
                end else if (haddr[11:0] == `DOPAG_OFF_CNT) begin
                    hrdata <= {16'h0, dec_count};
                end else begin
                    hrdata <= 32'h00000000; // Unmapped reads as zero
                end
            end
        end
    end
endmodule // dopag_top

// >>> tb/dopag_monitor.sv
/*
 Checker of the operand address generator: decode timing and field relations.
 Assumes it is bound to dopag_top and sees only that module's ports.
*/
`timescale 1ns/1ps
`include "dopag_consts.vh"
module dopag_monitor #(
    parameter AW = 12
) (
    input wire clk,
    input wire rst,
    input wire dec_valid,
    input wire [15:0] dec_opcode,
    input wire [15:0] dec_opcode2,
    input wire op_valid,
    input wire [2:0] op_mode,
    input wire [AW-1:0] op_src_addr,
    input wire [AW-1:0] op_dst_addr,
    input wire op_dst_wreg,
    input wire op_src_mem,
    input wire [19:0] op_literal,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready
);
////////////////////////////////////////////////////////////////////////////////
reg [15:0] op_q; // Opcode words caught at each strobe
reg [15:0] op2_q;
reg wr_ctl; // Control word write is in its data phase
reg ext_on; // Shadow of the extended enable bit
wire [3:0] nib = dec_opcode[15:12]; // Opcode group
wire byte_op = (nib >= 4'h1) && (nib <= 4'hB); // Byte and bit group

// Shadow of the control bit, so the indexed check knows the mode
always @(posedge clk) begin
    if (rst) begin
        wr_ctl <= 1'b0;
        ext_on <= 1'b0;
    end else begin
        wr_ctl <= hsel && hready && htrans[1] && hwrite && (haddr[11:0] == 12'h000);
        if (wr_ctl) begin
            ext_on <= hwdata[0];
        end
    end
end
// Captured words stand in for $past on slices, which some tools reject
always @(posedge clk) begin
    if (dec_valid) begin
        op_q <= dec_opcode;
        op2_q <= dec_opcode2;
    end
end
////////////////////////////////////////////////////////////////////////////////
default clocking mon_cb @(posedge clk); endclocking
default disable iff (rst);

chk_strobe_answer: assert property (
    dec_valid |=> op_valid ##1 !op_valid) else $error("answer pulse missing or long");
chk_answer_cause: assert property (
    op_valid |-> $past(dec_valid)) else $error("answer without a strobe");
chk_access_low: assert property (
    dec_valid && !ext_on && byte_op && !dec_opcode[8] && !dec_opcode[7]
    |=> op_mode == `DOPAG_MODE_DIR
    && op_src_addr == {4'h0, op_q[7:0]}) else $error("low access bank address wrong");
chk_indexed_on: assert property (
    dec_valid && ext_on && byte_op && !dec_opcode[8] && dec_opcode[7:0] <= 8'h5F
    |=> op_mode == `DOPAG_MODE_IDX) else $error("indexed mode missing");
chk_dest_bit: assert property (
    dec_valid && byte_op && nib < 4'h7 |=> op_dst_wreg == !op_q[9])
    else $error("destination bit ignored");
chk_fixed_dest: assert property (
    dec_valid && nib >= 4'h7 && nib <= 4'hB |=> !op_dst_wreg) else $error("fixed dest wrong");
chk_move_addr: assert property (
    dec_valid && nib == 4'hC |=> op_mode == `DOPAG_MODE_MOV && op_src_addr == op_q[11:0]
    && op_dst_addr == op2_q[11:0]) else $error("full address move wrong");
chk_inherent_op: assert property (
    dec_valid && dec_opcode[15:8] == 8'h00 |=> op_mode == `DOPAG_MODE_INH && !op_src_mem)
    else $error("inherent opcode decoded wrong");
chk_literal_byte: assert property (
    dec_valid && dec_opcode[15:9] == 7'h07 |=> op_mode == `DOPAG_MODE_LIT
    && op_literal[7:0] == op_q[7:0]) else $error("literal value wrong");
chk_no_indexed: assert property (
    op_valid && !ext_on |-> op_mode != `DOPAG_MODE_IDX) else $error("indexed mode while off");

cover property (dec_valid && nib == 4'hC);
cover property (op_valid && op_mode == `DOPAG_MODE_IDX);
cover property (op_valid && op_mode == `DOPAG_MODE_IND);
cover property (op_valid && op_mode == `DOPAG_MODE_DIR && !op_dst_wreg);
endmodule // dopag_monitor

bind dopag_top dopag_monitor #(.AW(AW)) dopag_monitor_i (
    .clk(clk), .rst(rst), .dec_valid(dec_valid), .dec_opcode(dec_opcode),
    .dec_opcode2(dec_opcode2), .op_valid(op_valid), .op_mode(op_mode),
    .op_src_addr(op_src_addr), .op_dst_addr(op_dst_addr), .op_dst_wreg(op_dst_wreg),
    .op_src_mem(op_src_mem), .op_literal(op_literal), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready)
);

// >>> tb/dopag_partner.sv
/*
 Model of the decoder and data memory facing the address generator.
 Assumes the bench calls its tasks just after a rising clock edge.
*/
`timescale 1ns/1ps
module dopag_partner (
    input wire logic clk,
    output logic dec_valid,
    output logic [15:0] dec_opcode,
    output logic [15:0] dec_opcode2,
    output logic [7:0] dec_wreg,
    output logic mem_we,
    output logic [11:0] mem_waddr,
    output logic [7:0] mem_wdata
);
////////////////////////////////////////////////////////////////////////////////
// Idle state at time zero; accumulator fixed, used by the plus W alias
initial begin
    dec_valid = 1'b0;
    dec_opcode = 16'h0000;
    dec_opcode2 = 16'h0000;
    dec_wreg = 8'h10;
    mem_we = 1'b0;
    mem_waddr = 12'h000;
    mem_wdata = 8'h00;
end
// One decoded instruction; words are scrambled after use so stale data never matches
task automatic issue(input logic [15:0] op, input logic [15:0] op2);
    dec_valid <= 1'b1;
    dec_opcode <= op;
    dec_opcode2 <= op2;
    @(posedge clk);
    dec_valid <= 1'b0;
    dec_opcode <= ~op;
    dec_opcode2 <= ~op2;
endtask
// One core write into the data map
task automatic poke(input logic [11:0] a, input logic [7:0] d);
    mem_we <= 1'b1;
    mem_waddr <= a;
    mem_wdata <= d;
    @(posedge clk);
    mem_we <= 1'b0;
    mem_waddr <= ~a;
    mem_wdata <= ~d;
endtask
endmodule // dopag_partner

// >>> tb/dopag_tb_top.sv
/*
 Self-checking bench of the operand address generator.
 Assumes the design and constants header are compiled alongside.
*/
`timescale 1ns/1ps
`include "dopag_consts.vh"
module dopag_tb_top;
logic clk, rst, hsel, hwrite; // Clock, reset and bus controls
logic [31:0] haddr, hwdata, rdv;
logic [1:0] htrans;
logic [2:0] hsize;
wire hready, hreadyout, hresp, dec_valid, mem_we, op_valid, op_dst_wreg, op_src_mem;
wire [31:0] hrdata;
wire [15:0] dec_opcode, dec_opcode2;
wire [7:0] dec_wreg, mem_wdata;
wire [11:0] mem_waddr, op_src_addr, op_dst_addr;
wire [2:0] op_mode;
wire [19:0] op_literal;
int error_cnt, compares, cycles;
assign hready = hreadyout; // Single slave drives the bus ready
always #20 clk = ~clk;
////////////////////////////////////////////////////////////////////////////////
dopag_partner dopag_partner_i (.clk(clk), .dec_valid(dec_valid), .dec_opcode(dec_opcode),
    .dec_opcode2(dec_opcode2), .dec_wreg(dec_wreg), .mem_we(mem_we), .mem_waddr(mem_waddr),
    .mem_wdata(mem_wdata));
dopag_top #(.AW(12)) dopag_top_i (.clk(clk), .rst(rst), .dec_valid(dec_valid),
    .dec_opcode(dec_opcode), .dec_opcode2(dec_opcode2), .dec_wreg(dec_wreg),
    .mem_we(mem_we), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata), .op_valid(op_valid),
    .op_mode(op_mode), .op_src_addr(op_src_addr), .op_dst_addr(op_dst_addr),
    .op_dst_wreg(op_dst_wreg), .op_src_mem(op_src_mem), .op_literal(op_literal),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
////////////////////////////////////////////////////////////////////////////////
task automatic tally_and_finish;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
endtask
// Compare of decode results
task automatic check_val(input string n, input logic [19:0] e, input logic [19:0] g);
    compares++;
    if (g !== e) begin
        error_cnt++;
        $display("Error %s expected %h seen %h", n, e, g);
    end
endtask
// Compare of bus read data
task automatic check_reg(input logic [11:0] a, input logic [31:0] e);
    compares++;
    if (rdv !== e) begin
        error_cnt++;
        $display("Error reg_%h expected %h seen %h", a, e, rdv);
    end
endtask
// One single word transfer; waits on ready, the cycle limit ends any hang
task automatic ahb(input logic [11:0] a, input logic w, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {20'h00000, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rdv = hrdata;
endtask
task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    ahb(a, 1'b0, 32'h00000000);
    check_reg(a, e);
    check_val("hresp", 20'h00000, hresp);
endtask
// Decode one instruction and judge the answer one cycle later
task automatic dec(input logic [15:0] op, op2, input logic [2:0] m,
    input logic [11:0] src, input logic wr);
    dopag_partner_i.issue(op, op2);
    @(posedge clk);
    check_val("op_valid", 20'h00001, op_valid);
    check_val("op_mode", m, op_mode);
    check_val("op_src_mem", {19'h0, m >= `DOPAG_MODE_DIR}, op_src_mem);
    if (m >= `DOPAG_MODE_DIR) check_val("op_src_addr", src, op_src_addr);
    if (m == `DOPAG_MODE_DIR || m == `DOPAG_MODE_IND) check_val("op_dst_wreg", wr, op_dst_wreg);
    if (m != `DOPAG_MODE_MOV && m >= `DOPAG_MODE_DIR && !wr) check_val("op_dst_addr", src, op_dst_addr);
    repeat (3) @(posedge clk); // Pointer updates settle before the next strobe
endtask
////////////////////////////////////////////////////////////////////////////////
task automatic t_regs;
    rd_chk(`DOPAG_OFF_CTRL, 32'h00000000);
    rd_chk(`DOPAG_OFF_BANK, 32'h00000000);
    rd_chk(`DOPAG_OFF_PTR0, 32'h00000000);
    rd_chk(12'h040, 32'h00000000); // Unmapped place reads zero
    ahb(`DOPAG_OFF_CTRL, 1'b1, 32'h00000001);
    rd_chk(`DOPAG_OFF_CTRL, 32'h00000001);
    ahb(`DOPAG_OFF_CTRL, 1'b1, 32'h00000000);
    $display("test regs done");
endtask
task automatic t_direct;
    dopag_partner_i.poke(`DOPAG_SFR_BANK, 8'h05);
    repeat (3) @(posedge clk);
    dec(16'h2334, 16'h0000, `DOPAG_MODE_DIR, 12'h534, 1'b0);
    dec(16'h2034, 16'h0000, `DOPAG_MODE_DIR, 12'h034, 1'b1);
    dec(16'h2090, 16'h0000, `DOPAG_MODE_DIR, 12'hF90, 1'b1);
    ahb(`DOPAG_OFF_BANK, 1'b1, 32'h0000000A);
    dec(16'h2134, 16'h0000, `DOPAG_MODE_DIR, 12'hA34, 1'b1);
    dec(16'h7234, 16'h0000, `DOPAG_MODE_DIR, 12'h034, 1'b0);
    dec(16'hC123, 16'hF456, `DOPAG_MODE_MOV, 12'h123, 1'b0);
    check_val("op_dst_addr", 20'h00456, op_dst_addr);
    $display("test direct done");
endtask
task automatic t_inh_lit;
    dec(16'h0003, 16'h0000, `DOPAG_MODE_INH, 12'h000, 1'b0);
    dec(16'h0E5A, 16'h0000, `DOPAG_MODE_LIT, 12'h000, 1'b0);
    check_val("op_literal", 20'h0005A, op_literal);
    dec(16'hEF12, 16'hF345, `DOPAG_MODE_LIT, 12'h000, 1'b0);
    check_val("op_literal", 20'h34512, op_literal);
    $display("test inherent literal done");
endtask
task automatic t_indirect;
    dopag_partner_i.poke(`DOPAG_SFR_PTR0L, 8'h20);
    repeat (3) @(posedge clk); // High byte merges with the settled low byte
    dopag_partner_i.poke(`DOPAG_SFR_PTR0H, 8'h01);
    repeat (3) @(posedge clk);
    rd_chk(`DOPAG_OFF_PTR0, 32'h00000120);
    dec(16'h50EF, 16'h0000, `DOPAG_MODE_IND, 12'h120, 1'b1);
    dec(16'h50EE, 16'h0000, `DOPAG_MODE_IND, 12'h120, 1'b1);
    dec(16'h50ED, 16'h0000, `DOPAG_MODE_IND, 12'h121, 1'b1);
    dec(16'h50EC, 16'h0000, `DOPAG_MODE_IND, 12'h121, 1'b1);
    dec(16'h50EB, 16'h0000, `DOPAG_MODE_IND, 12'h131, 1'b1);
    ahb(`DOPAG_OFF_PTR1, 1'b1, 32'h00000345);
    repeat (3) @(posedge clk); // Pointer read data lag the bus write
    dec(16'h52E7, 16'h0000, `DOPAG_MODE_IND, 12'h345, 1'b0);
    rd_chk(`DOPAG_OFF_STAT, 32'h00000003);
    rd_chk(`DOPAG_OFF_CNT, 32'h0000000F);
    $display("test indirect done");
endtask
task automatic t_indexed;
    ahb(`DOPAG_OFF_PTR2, 1'b1, 32'h00000200);
    ahb(`DOPAG_OFF_CTRL, 1'b1, 32'h00000001);
    repeat (3) @(posedge clk); // Pointer read data lag the bus write
    dec(16'h2010, 16'h0000, `DOPAG_MODE_IDX, 12'h210, 1'b1);
    ahb(`DOPAG_OFF_CTRL, 1'b1, 32'h00000000);
    dec(16'h2010, 16'h0000, `DOPAG_MODE_DIR, 12'h010, 1'b1);
    $display("test indexed done");
endtask
////////////////////////////////////////////////////////////////////////////////
// Cycle limit: the whole run needs about 140 cycles
always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
        error_cnt++;
        $display("Error cycle_limit expected 3000 seen %0d", cycles);
        tally_and_finish;
    end
end
initial begin
    clk = 1'b0;
    rst = 1'b1;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2; // Whole words only
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_direct;
    t_inh_lit;
    t_indirect;
    t_indexed;
    tally_and_finish;
end
endmodule // dopag_tb_top
